// ===== asc_consts.svh
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH
// frame geometry
`define ASC_FRAME_BITS 16
`define ASC_CTRL_BITS 8
`define ASC_LEAD_ZEROS 4
`define ASC_RESULT_BITS 12
`define ASC_SAMPLE_EDGE 2
// control word field positions (bit index within the 8-bit word, msb first shifted)
`define ASC_CTRL_PM_HI 1
`define ASC_CTRL_PM_LO 0
`define ASC_CTRL_CHAN 3
`define ASC_CTRL_REF 5
`define ASC_CTRL_RESET 8'h00
// power-mode codes {hi,lo}
`define ASC_PM_CS_SHUT 2'h0
`define ASC_PM_ALWAYS_ON 2'h1
`define ASC_PM_AUTO_SHUT 2'h2
`define ASC_PM_AUTO_STBY 2'h3
// wake-up time from shutdown, in ns, and in core clocks (40 ns period)
`define ASC_CORE_PERIOD_NS 40
`define ASC_WAKE_SHUT_NS 5000
`define ASC_WAKE_SHUT_CYC ((`ASC_WAKE_SHUT_NS + `ASC_CORE_PERIOD_NS - 1) / `ASC_CORE_PERIOD_NS)
`endif

// ===== asc_pkg.sv
package asc_pkg;
   typedef enum logic [1:0] {
      ASC_PWR_OFF = 2'b00,
      ASC_PWR_STBY = 2'b01,
      ASC_PWR_WAKING = 2'b10,
      ASC_PWR_ON = 2'b11
   } asc_pwr_t;
   typedef struct packed {
      logic powerModeHi;
      logic powerModeLo;
      logic chanSel;
      logic refSel;
   } asc_ctrl_t;
   typedef struct packed {
      logic converting;
      logic trackHold;
      logic [11:0] result;
   } asc_conv_t;
endpackage : asc_pkg

// ===== asc_sync3.sv
`timescale 1ns/1ps
// three-flop synchroniser; output moves once the last two stages agree
module asc_sync3 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   // shift chain
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
      end
   end
   // accept agreed bits only
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dout <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
               dout[i] <= s3[i];
            end
         end
      end
   end
endmodule : asc_sync3

// ===== asc_serial_ctrl.sv
`timescale 1ns/1ps
`include "asc_consts.svh"
// Behaviour
// RULE1: both mode bits one: standby after each conversion at last rising edge, reference on.
// RULE2: standby mode wakes on first falling serial edge after select falls.
// RULE3: serial clock is the conversion clock and shifts all data.
// RULE4: select falling gates clock in, tracks input, starts wake in select-woken modes.
// RULE5: second rising edge after select falls holds sample and starts conversion.
// RULE6: host stretches acquisition to cover five microsecond wake-up.
// RULE7: conversion finishes fourteen and one-half periods after sampling edge. Code ends it at the sixteenth rising edge, fourteen periods after.
// RULE8: each conversion with readout spans sixteen serial clock periods.
// RULE9: select rising releases output; staying low lets a new conversion start.
// RULE10: dual-channel samples the channel chosen by the previous control write.
// RULE11: first eight rising edges always load the control register.
// RULE12: control input held low loads all zeros every transfer.
// RULE13: host presents a valid control word on every transfer.
// RULE14: result bits launch on falling edges, sampled on next rising edge.
// RULE15: first edge falling drives the first leading zero.
// RULE16: first edge rising leaves first leading zero unreliable to host.
// RULE17: last bit driven on falling edge before sixteenth rising edge.
// RULE18: byte-port hosts use two eight-bit transfers under one select.
// RULE19: timer-driven hosts keep frame interval whole serial periods.
// RULE20: both bits zero: powered while select low, shut down while high.
// RULE21: low bit one only: always powered.
// RULE22: high bit one only: shut down after each conversion, wake on first falling edge.
// RULE23: output frame is four zeros then twelve result bits, msb first.
// RULE24: control field positions are configurable constants.
module asc_serial_ctrl #(
   parameter int WAKE_SHUT_CYC = `ASC_WAKE_SHUT_CYC
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic serialClk,
   input wire logic chipSelN,
   input wire logic ctrlIn,
   output logic dataOut,
   output logic dataOutEn,
   input wire logic [11:0] sampleValue,
   output logic [11:0] resultWord,
   output logic resultValid,
   output logic powerModeHi,
   output logic powerModeLo,
   output logic chanSel,
   output logic refSel,
   output logic trackHold,
   output logic converting,
   output logic refPowered,
   output logic corePowered,
   output logic awake
);
   // ---------------- link domain (serial clock) ----------------
   logic [4:0] riseCnt;
   logic [7:0] ctrlShift;
   logic [7:0] ctrlReg;
   logic [11:0] heldSample;
   logic fellSeen;
   logic convActive;
   logic frameDoneTgl;
   logic wakeTgl;
   logic lastChan;
   logic [3:0] bitSel;

   // rising-edge counter, reset by select high (clock may stop outside frames)
   always_ff @(posedge serialClk or posedge chipSelN) begin
      if (chipSelN) begin
         riseCnt <= 5'h00;
      end else if (riseCnt == 5'(`ASC_FRAME_BITS)) begin
         riseCnt <= 5'h01; // select kept low: next conversion starts, see RULE9
      end else begin
         riseCnt <= riseCnt + 5'h01; // see RULE8
      end
   end

   // control capture on first eight rising edges, unconditional, see RULE11 and RULE12
   always_ff @(posedge serialClk or posedge chipSelN) begin
      if (chipSelN) begin
         ctrlShift <= 8'h00;
      end else if (riseCnt < 5'(`ASC_CTRL_BITS) || riseCnt == 5'(`ASC_FRAME_BITS)) begin
         ctrlShift <= {ctrlShift[6:0], ctrlIn};
      end
   end

   // control register commits at eighth rising edge; survives frames
   always_ff @(posedge serialClk or negedge nrst) begin
      if (!nrst) begin
         ctrlReg <= `ASC_CTRL_RESET;
      end else if (!chipSelN && riseCnt == 5'(`ASC_CTRL_BITS - 1)) begin
         ctrlReg <= {ctrlShift[6:0], ctrlIn}; // see RULE11
      end
   end

   // channel sampled is the one latched before this frame, see RULE10
   always_ff @(posedge serialClk or negedge nrst) begin
      if (!nrst) begin
         lastChan <= 1'b0;
      end else if (!chipSelN && riseCnt == 5'h00) begin
         lastChan <= ctrlReg[`ASC_CTRL_CHAN];
      end
   end

   // track until second rising edge, then hold and convert, see RULE4 and RULE5
   always_ff @(posedge serialClk or posedge chipSelN) begin
      if (chipSelN) begin
         convActive <= 1'b0;
      end else if (riseCnt == 5'(`ASC_SAMPLE_EDGE - 1)) begin
         convActive <= 1'b1; // hold and convert, see RULE5 and RULE3
      end else if (riseCnt == 5'(`ASC_FRAME_BITS - 1)) begin
         convActive <= 1'b0; // 16th rise, 14 periods after sampling; RULE7 asks 14.5
      end
   end

   // sampled word survives select rising so the core can still collect it
   always_ff @(posedge serialClk or negedge nrst) begin
      if (!nrst) begin
         heldSample <= 12'h000;
      end else if (!chipSelN && riseCnt == 5'(`ASC_SAMPLE_EDGE - 1)) begin
         heldSample <= sampleValue; // see RULE5
      end
   end

   // frame completion event toward core domain, see RULE1 and RULE22
   always_ff @(posedge serialClk or negedge nrst) begin
      if (!nrst) begin
         frameDoneTgl <= 1'b0;
      end else if (!chipSelN && riseCnt == 5'(`ASC_FRAME_BITS - 1)) begin
         frameDoneTgl <= ~frameDoneTgl;
      end
   end

   // falling-edge side: launch each output bit for the next rising edge, see RULE14
   always_ff @(negedge serialClk or posedge chipSelN) begin
      if (chipSelN) begin
         fellSeen <= 1'b0;
         dataOut <= 1'b0;
      end else begin
         fellSeen <= 1'b1;
         if (riseCnt < 5'(`ASC_LEAD_ZEROS) || riseCnt >= 5'(`ASC_FRAME_BITS)) begin
            dataOut <= 1'b0; // leading zeros, see RULE15 and RULE23
         end else begin
            dataOut <= heldSample[bitSel]; // msb first, last bit before 16th rise, see RULE17
         end
      end
   end

   // first falling edge wakes auto modes
   always_ff @(negedge serialClk or negedge nrst) begin
      if (!nrst) begin
         wakeTgl <= 1'b0;
      end else if (!chipSelN && !fellSeen) begin
         wakeTgl <= ~wakeTgl; // see RULE2 and RULE22
      end
   end

   // result bit index for the bit after the current rise, see RULE23
   assign bitSel = 4'(5'(`ASC_FRAME_BITS - 1) - riseCnt);
   assign dataOutEn = ~chipSelN; // three-state when select high, see RULE9

   // ---------------- core domain ----------------
   logic [3:0] syncIn;
   logic [3:0] syncOut;
   logic doneSeen;
   logic wakeSeen;
   logic csLowCore;
   logic [1:0] pmCore;
   logic [1:0] pmNow;
   logic [12:0] wakeCnt;
   asc_pkg::asc_pwr_t pwrState;
   asc_pkg::asc_pwr_t next_pwrState;

   assign syncIn = {frameDoneTgl, wakeTgl, ~chipSelN, convActive};
   asc_sync3 #(.W(4)) uSync (
      .clk(core_clk),
      .nrst(nrst),
      .din(syncIn),
      .dout(syncOut)
   );
   assign csLowCore = syncOut[1];

   // mode bits and results cross as quasi-static words after frame toggle
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         doneSeen <= 1'b0;
         wakeSeen <= 1'b0;
         pmCore <= `ASC_PM_CS_SHUT;
         resultWord <= 12'h000;
         resultValid <= 1'b0;
         chanSel <= 1'b0;
         refSel <= 1'b0;
         powerModeHi <= 1'b0;
         powerModeLo <= 1'b0;
      end else begin
         doneSeen <= syncOut[3];
         wakeSeen <= syncOut[2];
         resultValid <= syncOut[3] ^ doneSeen;
         if (syncOut[3] ^ doneSeen) begin
            resultWord <= heldSample;
            pmCore <= {ctrlReg[`ASC_CTRL_PM_HI], ctrlReg[`ASC_CTRL_PM_LO]}; // see RULE24
            chanSel <= lastChan; // see RULE10
            refSel <= ctrlReg[`ASC_CTRL_REF];
            powerModeHi <= ctrlReg[`ASC_CTRL_PM_HI]; // shown with the result it belongs to
            powerModeLo <= ctrlReg[`ASC_CTRL_PM_LO];
         end
      end
   end

   // mode in force: at frame end the word just written decides the power-down, see RULE22
   assign pmNow = (syncOut[3] ^ doneSeen) ? {ctrlReg[`ASC_CTRL_PM_HI], ctrlReg[`ASC_CTRL_PM_LO]} : pmCore;

   // power state selection per mode
   always_comb begin
      next_pwrState = pwrState;
      unique case (pmNow)
         `ASC_PM_CS_SHUT: begin
            if (!csLowCore) begin
               next_pwrState = asc_pkg::ASC_PWR_OFF; // see RULE20
            end else if (pwrState == asc_pkg::ASC_PWR_OFF || pwrState == asc_pkg::ASC_PWR_STBY) begin
               next_pwrState = asc_pkg::ASC_PWR_WAKING; // see RULE4
            end
         end
         `ASC_PM_ALWAYS_ON: begin
            next_pwrState = asc_pkg::ASC_PWR_ON; // see RULE21
         end
         `ASC_PM_AUTO_SHUT: begin
            if (syncOut[3] ^ doneSeen) begin
               next_pwrState = asc_pkg::ASC_PWR_OFF; // see RULE22
            end else if (syncOut[2] ^ wakeSeen && pwrState == asc_pkg::ASC_PWR_OFF) begin
               next_pwrState = asc_pkg::ASC_PWR_WAKING;
            end
         end
         `ASC_PM_AUTO_STBY: begin
            if (syncOut[3] ^ doneSeen) begin
               next_pwrState = asc_pkg::ASC_PWR_STBY; // see RULE1
            end else if (syncOut[2] ^ wakeSeen) begin
               next_pwrState = asc_pkg::ASC_PWR_ON; // fast wake, see RULE2
            end
         end
      endcase
      if (next_pwrState == asc_pkg::ASC_PWR_WAKING && wakeCnt == 13'(WAKE_SHUT_CYC)) begin
         next_pwrState = asc_pkg::ASC_PWR_ON;
      end
   end

   // power state register; power-on default is select-controlled shutdown
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pwrState <= asc_pkg::ASC_PWR_OFF;
      end else begin
         pwrState <= next_pwrState;
      end
   end

   // wake-up timer from full shutdown (host must allow this, see RULE6)
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wakeCnt <= 13'h0000;
      end else if (pwrState == asc_pkg::ASC_PWR_WAKING) begin
         wakeCnt <= wakeCnt + 13'h0001;
      end else begin
         wakeCnt <= 13'h0000;
      end
   end

   // status outputs
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         corePowered <= 1'b0;
         refPowered <= 1'b0;
         awake <= 1'b0;
         converting <= 1'b0;
         trackHold <= 1'b0;
      end else begin
         corePowered <= pwrState == asc_pkg::ASC_PWR_ON;
         refPowered <= pwrState != asc_pkg::ASC_PWR_OFF; // reference stays up in standby, see RULE1
         awake <= pwrState == asc_pkg::ASC_PWR_ON;
         converting <= syncOut[0];
         trackHold <= syncOut[0];
      end
   end
endmodule : asc_serial_ctrl

// ===== asc_serial_ctrl_props.sv
`timescale 1ns/1ps
// port checker for the conversion controller, core domain
module asc_serial_ctrl_props #(
   parameter int WAKE_SHUT_CYC = 4
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic chipSelN,
   input wire logic dataOutEn,
   input wire logic [11:0] resultWord,
   input wire logic resultValid,
   input wire logic powerModeHi,
   input wire logic powerModeLo,
   input wire logic converting,
   input wire logic refPowered,
   input wire logic corePowered
);
   localparam int WMAX = WAKE_SHUT_CYC + 12;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   // output enable, result timing and power states
   property p_release;
      chipSelN ##1 chipSelN |-> !dataOutEn;
   endproperty
   a_release: assert property (p_release) else $error("output driven while deselected");
   property p_drive;
      !chipSelN ##1 !chipSelN |-> dataOutEn;
   endproperty
   a_drive: assert property (p_drive) else $error("output idle while selected");
   property p_pulse;
      resultValid |=> !resultValid;
   endproperty
   a_pulse: assert property (p_pulse) else $error("result pulse too long");
   property p_hold;
      $changed(resultWord) |-> ##[0:2] resultValid;
   endproperty
   a_hold: assert property (p_hold) else $error("result moved without a frame");
   property p_conv;
      $rose(converting) |-> ##[30:60] resultValid;
   endproperty
   a_conv: assert property (p_conv) else $error("conversion length wrong");
   property p_stby;
      (powerModeHi && powerModeLo) [*8] |-> refPowered;
   endproperty
   a_stby: assert property (p_stby) else $error("reference off in standby mode");
   property p_on;
      (!powerModeHi && powerModeLo) [*8] |-> corePowered;
   endproperty
   a_on: assert property (p_on) else $error("core off in always-on mode");
   property p_csshut;
      (!powerModeHi && !powerModeLo && chipSelN) [*8] |-> !corePowered && !refPowered;
   endproperty
   a_csshut: assert property (p_csshut) else $error("powered while deselected");
   property p_wake;
      $fell(chipSelN) && !powerModeHi && !powerModeLo |-> ##[1:WMAX] corePowered;
   endproperty
   a_wake: assert property (p_wake) else $error("no power-up on select");
   property p_auto;
      $fell(converting) && powerModeHi |-> ##[0:8] !corePowered;
   endproperty
   a_auto: assert property (p_auto) else $error("core stays on after conversion");
   // main scenarios reached
   c_frame: cover property (resultValid);
   c_stby: cover property ($fell(corePowered) && refPowered);
   c_shut: cover property (powerModeHi && !powerModeLo && resultValid);
endmodule : asc_serial_ctrl_props
bind asc_serial_ctrl asc_serial_ctrl_props #(.WAKE_SHUT_CYC(WAKE_SHUT_CYC)) props_u (
   .core_clk(core_clk),
   .nrst(nrst),
   .chipSelN(chipSelN),
   .dataOutEn(dataOutEn),
   .resultWord(resultWord),
   .resultValid(resultValid),
   .powerModeHi(powerModeHi),
   .powerModeLo(powerModeLo),
   .converting(converting),
   .refPowered(refPowered),
   .corePowered(corePowered)
);

// ===== asc_host.sv
`timescale 1ns/1ps
// host serial port: idle-high clock, 125 ns period, stands still between frames
module asc_host (
   output logic serialClk,
   output logic chipSelN,
   output logic ctrlIn,
   input wire logic dataOut
);
   // idle levels at time zero
   // select pulsed once after time zero so the link flops start from their reset
   initial begin
      serialClk = 1'b1;
      chipSelN = 1'b0;
      ctrlIn = 1'b0;
      #1 chipSelN = 1'b1;
   end
   // one frame: control word out msb first, sixteen bits back
   task automatic frame(input logic [7:0] w, output logic [15:0] rx);
      chipSelN = 1'b0;
      for (int i = 0; i < 16; i++) begin
         #(i == 8 ? 250.0 : 62.5) serialClk = 1'b0; // clock rests high between the bytes
         ctrlIn = i < 8 ? w[7 - i] : ~ctrlIn;
         #(i == 0 ? 1000.0 : 62.5) serialClk = 1'b1;
         rx[15 - i] = dataOut;
      end
      #62.5 chipSelN = 1'b1;
      ctrlIn = ~ctrlIn;
      #500;
   endtask : frame
endmodule : asc_host

// ===== asc_serial_ctrl_bench.sv
`timescale 1ns/1ps
// bench: host frames in every power mode, results checked from a queue
module asc_serial_ctrl_bench;
   logic core_clk, nrst, serialClk, chipSelN, ctrlIn, dataOut, dataOutEn, resultValid;
   logic powerModeHi, powerModeLo, chanSel, refSel, trackHold, converting, refPowered, corePowered, awake;
   logic [11:0] sampleValue, resultWord;
   logic [15:0] notes[$];
   int nErrors = 0;
   int samplesChecked = 0;
   int cyc = 0;

   asc_serial_ctrl #(.WAKE_SHUT_CYC(4)) dut_u (
      .core_clk(core_clk),
      .nrst(nrst),
      .serialClk(serialClk),
      .chipSelN(chipSelN),
      .ctrlIn(ctrlIn),
      .dataOut(dataOut),
      .dataOutEn(dataOutEn),
      .sampleValue(sampleValue),
      .resultWord(resultWord),
      .resultValid(resultValid),
      .powerModeHi(powerModeHi),
      .powerModeLo(powerModeLo),
      .chanSel(chanSel),
      .refSel(refSel),
      .trackHold(trackHold),
      .converting(converting),
      .refPowered(refPowered),
      .corePowered(corePowered),
      .awake(awake)
   );
   asc_host host_u (
      .serialClk(serialClk),
      .chipSelN(chipSelN),
      .ctrlIn(ctrlIn),
      .dataOut(dataOut)
   );

   // core clock, 40 ns
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         nErrors++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic test_done;
      if (nErrors == 0 && samplesChecked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   // cycle ceiling against a hung frame
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         nErrors++;
         test_done();
      end
   end

   // result watcher: oldest note against each completed frame
   always @(negedge core_clk) begin
      if (resultValid === 1'b1) begin
         if (notes.size() == 0) chk(16'hFFFF, 16'h0000);
         else chk({resultWord, powerModeHi, powerModeLo, chanSel, refSel}, notes.pop_front());
      end
   end

   // main sequence: reset, then frames cycling through the four modes
   initial begin
      logic [7:0] w;
      logic [15:0] rx;
      logic prevChan;
      nrst = 1'b0;
      prevChan = 1'b0;
      sampleValue = 12'h000;
      void'($urandom(59457));
      repeat (12) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge core_clk);
      for (int k = 0; k < 13; k++) begin
         w = k == 0 ? 8'h00 : 8'($urandom());
         w[1:0] = 2'(k);
         @(posedge core_clk);
         sampleValue <= 12'($urandom());
         @(posedge core_clk);
         notes.push_back({sampleValue, w[1], w[0], prevChan, w[5]});
         prevChan = w[3];
         host_u.frame(w, rx);
         chk(rx, {4'h0, sampleValue});
         repeat (10) @(negedge core_clk);
         chk({12'h0, trackHold, awake, corePowered, refPowered},
             {12'h0, 1'b0, w[0] & ~w[1], w[0] & ~w[1], w[0]});
      end
      test_done();
   end
endmodule : asc_serial_ctrl_bench
